// ===== rtl/axis_amp_pkg.sv
package axis_amp_pkg;
    localparam int NUM_AXES   = 8;
    localparam int GROUP_SIZE = 4;

    // address split: bit 8 picks the axis region
    localparam int AXIS_SEL_BIT = 8;
    localparam int AXIS_IDX_LSB = 5;
    localparam int REG_IDX_LSB  = 2;

    // global word indexes
    localparam logic [2:0] G_IRQ_STATUS = 3'h0;
    localparam logic [2:0] G_IRQ_MASK   = 3'h1;
    localparam logic [2:0] G_POLARITY   = 3'h2;
    localparam logic [2:0] G_WDOG_LOAD  = 3'h3;
    localparam logic [2:0] G_WDOG_KICK  = 3'h4;

    // per-axis word indexes
    localparam logic [2:0] A_CTRL      = 3'h0;
    localparam logic [2:0] A_POSITION  = 3'h1;
    localparam logic [2:0] A_TARGET    = 3'h2;
    localparam logic [2:0] A_ERR_LIMIT = 3'h3;
    localparam logic [2:0] A_TORQUE    = 3'h4;
    localparam logic [2:0] A_COMMAND   = 3'h5;
    localparam logic [2:0] A_STATUS    = 3'h6;
    localparam logic [2:0] A_HALL_BASE = 3'h7;

    // control word fields
    localparam int CTRL_ENABLE    = 0;
    localparam int CTRL_MOTOR_OFF = 1;
    localparam int CTRL_OE_LSB    = 4;
    localparam int CTRL_PULSE_DIR = 8;
    localparam int CTRL_DIFF      = 9;
    localparam int CTRL_INDEX_EN  = 10;
    localparam int CTRL_PHASE_LSB = 12;
    localparam int CTRL_PHASE_SET = 15;

    // polarity word fields
    localparam int POL_GROUP_LSB = 0;
    localparam int POL_PER_AXIS  = 8;
    localparam int POL_AXIS_LSB  = 16;
    localparam logic [31:0] POLARITY_RST = 32'h00FF_0003;

    localparam logic [1:0]  OE_MODE_ONE   = 2'h1;
    localparam logic [1:0]  OE_MODE_THREE = 2'h3;
    localparam logic [14:0] TORQUE_LIMIT_RST = 15'h7FDE;
    localparam logic [31:0] ERR_LIMIT_RST    = 32'h0000_07D0;
    localparam logic [6:0]  HALL_BASE_RST    = 7'h01;
    localparam logic [23:0] WDOG_LOAD_RST    = 24'h00_0000;

    typedef enum logic [1:0] {
        AMP_OFF = 2'b01,
        AMP_ON  = 2'b10
    } amp_state_t;
endpackage

// ===== rtl/axis_amp_enable_safety.sv
`timescale 1ns/1ps
module axis_amp_enable_safety
    import axis_amp_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire logic [8:0]                 avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [3:0]                 avs_byteenable,
    input  wire logic [31:0]                avs_writedata,
    output logic      [31:0]                avs_readdata,
    output logic                            avs_waitrequest,
    input  wire logic [NUM_AXES-1:0]        encoder_chan_a_pos,
    input  wire logic [NUM_AXES-1:0]        encoder_chan_a_neg,
    input  wire logic [NUM_AXES-1:0]        encoder_chan_b_pos,
    input  wire logic [NUM_AXES-1:0]        encoder_chan_b_neg,
    input  wire logic [NUM_AXES-1:0]        encoder_index_pos,
    input  wire logic [NUM_AXES-1:0]        encoder_index_neg,
    input  wire logic [96:1]                dig_in,
    output logic      [NUM_AXES-1:0]        amp_enable_out,
    output logic [NUM_AXES-1:0][15:0]       motor_command_out,
    output logic                            irq
);

////////////////////////////////////////////////////////////////////////
function automatic logic signed [1:0] quad_step(input logic [3:0] pc);
    case (pc)
        4'h1, 4'h7, 4'hE, 4'h8: quad_step = 2'sb01;
        4'h4, 4'hD, 4'hB, 4'h2: quad_step = -2'sb01;
        default:                quad_step = 2'sb00;
    endcase
endfunction

function automatic logic [2:0] hall_sector(input logic [2:0] h);
    case (h)
        3'h1:    hall_sector = 3'h0;
        3'h3:    hall_sector = 3'h1;
        3'h2:    hall_sector = 3'h2;
        3'h6:    hall_sector = 3'h3;
        3'h4:    hall_sector = 3'h4;
        default: hall_sector = 3'h5;
    endcase
endfunction

// three consecutive bits must sit inside one hall-capable bank
function automatic logic base_ok(input logic [6:0] b);
    base_ok = (b >= 7'd1  && b <= 7'd6)
           || (b >= 7'd17 && b <= 7'd78)
           || (b >= 7'd81 && b <= 7'd94);
endfunction

////////////////////////////////////////////////////////////////////////
logic              wait_r;
logic [31:0]       rdata_r;
logic [31:0]       rd_mux;
logic              wr_acc;
logic [2:0]        reg_idx;
logic [2:0]        axis_idx;
logic              glob_hit;
logic [NUM_AXES-1:0] wr_axis;

logic [16:0]       irq_status_r;
logic [16:0]       irq_mask_r;
logic [16:0]       irq_set;
logic              irq_r;
logic [31:0]       pol_r;
logic [23:0]       wdog_load_r;
logic [23:0]       wdog_cnt_r;
logic              wdog_reload;
logic              wdog_trip;
logic              boot_r;

amp_state_t        amp_state_r [NUM_AXES];
logic [31:0]       pos_r       [NUM_AXES];
logic [31:0]       target_r    [NUM_AXES];
logic [31:0]       err_lim_r   [NUM_AXES];
logic [14:0]       tl_r        [NUM_AXES];
logic [15:0]       cmd_r       [NUM_AXES];
logic [6:0]        base_r      [NUM_AXES];
logic [1:0]        oe_r        [NUM_AXES];
logic [1:0]        ab_prev_r   [NUM_AXES];
logic [2:0]        phase_r     [NUM_AXES];
logic [2:0]        hall_code   [NUM_AXES];
logic [15:0]       cmd_nxt     [NUM_AXES];
logic [NUM_AXES-1:0] pd_r, diff_r, idx_en_r, idx_prev_r;
logic [NUM_AXES-1:0] fault_wd_r, fault_err_r, off_cmd_r;
logic [NUM_AXES-1:0] phase_ok_r;
logic [NUM_AXES-1:0] encoder_input_a, encoder_input_b, enc_idx;
logic [NUM_AXES-1:0] amp_on, pol_eff, over_err, err_trip;
logic [NUM_AXES-1:0] mo_req, en_req, kill, idx_evt, hall_ok;
logic [NUM_AXES-1:0] pos_wr, pin_nxt;
logic [127:0]      din_ext;
logic [NUM_AXES-1:0][15:0] mcmd_r;
logic [NUM_AXES-1:0] amp_pin_r;

assign avs_waitrequest   = wait_r;
assign avs_readdata      = rdata_r;
assign irq               = irq_r;
assign amp_enable_out    = amp_pin_r;
assign motor_command_out = mcmd_r;

////////////////////////////////////////////////////////////////////////
// bus slave: one wait cycle, read data captured when the request is seen
assign reg_idx  = avs_address[REG_IDX_LSB +: 3];
assign axis_idx = avs_address[AXIS_IDX_LSB +: 3];
assign glob_hit = !avs_address[AXIS_SEL_BIT] && axis_idx == 3'h0;
// partial-word writes are ignored to keep multi-field words coherent
assign wr_acc   = avs_write && !wait_r && avs_byteenable == 4'hF;

always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        wait_r <= 1'b1;
    end else if (wait_r && (avs_read || avs_write)) begin
        wait_r <= 1'b0;
    end else begin
        wait_r <= 1'b1;
    end
end

always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        rdata_r <= 32'h0000_0000;
    end else if (wait_r && avs_read) begin
        rdata_r <= rd_mux;
    end
end

always_comb begin
    rd_mux = 32'h0000_0000;
    if (glob_hit) begin
        case (reg_idx)
            G_IRQ_STATUS: rd_mux = {15'h0000, irq_status_r};
            G_IRQ_MASK:   rd_mux = {15'h0000, irq_mask_r};
            G_POLARITY:   rd_mux = pol_r;
            G_WDOG_LOAD:  rd_mux = {8'h00, wdog_load_r};
            G_WDOG_KICK:  rd_mux = {8'h00, wdog_cnt_r};
            default:      rd_mux = 32'h0000_0000;
        endcase
    end else if (avs_address[AXIS_SEL_BIT]) begin
        case (reg_idx)
            A_CTRL: begin
                rd_mux[CTRL_OE_LSB +: 2]  = oe_r[axis_idx];
                rd_mux[CTRL_PULSE_DIR]    = pd_r[axis_idx];
                rd_mux[CTRL_DIFF]         = diff_r[axis_idx];
                rd_mux[CTRL_INDEX_EN]     = idx_en_r[axis_idx];
            end
            A_POSITION:  rd_mux = pos_r[axis_idx];
            A_TARGET:    rd_mux = target_r[axis_idx];
            A_ERR_LIMIT: rd_mux = err_lim_r[axis_idx];
            A_TORQUE:    rd_mux = {17'h00000, tl_r[axis_idx]};
            A_COMMAND:   rd_mux = {16'h0000, cmd_r[axis_idx]};
            A_STATUS: begin
                rd_mux[11:0] = {over_err[axis_idx],
                    hall_code[axis_idx], phase_r[axis_idx],
                    phase_ok_r[axis_idx], off_cmd_r[axis_idx],
                    fault_err_r[axis_idx], fault_wd_r[axis_idx],
                    amp_on[axis_idx]};
            end
            A_HALL_BASE: rd_mux = {25'h0000000, base_r[axis_idx]};
            default:     rd_mux = 32'h0000_0000;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// per-axis decode of inputs and kill terms
assign din_ext = {31'h0000_0000, dig_in, 1'b0};

always_comb begin
    for (int i = 0; i < NUM_AXES; i++) begin
        wr_axis[i] = wr_acc && avs_address[AXIS_SEL_BIT]
                  && axis_idx == 3'(i);
        // differential pairs need true high and complement low
        encoder_input_a[i] = encoder_chan_a_pos[i]
            && !(diff_r[i] && encoder_chan_a_neg[i]);
        encoder_input_b[i] = encoder_chan_b_pos[i]
            && !(diff_r[i] && encoder_chan_b_neg[i]);
        enc_idx[i] = encoder_index_pos[i]
            && !(diff_r[i] && encoder_index_neg[i]);
        hall_code[i] = din_ext[base_r[i] +: 3];
        hall_ok[i] = base_ok(base_r[i])
            && hall_code[i] != 3'h0 && hall_code[i] != 3'h7;
        amp_on[i] = amp_state_r[i] == AMP_ON;
        over_err[i] = ((target_r[i][31] == pos_r[i][31])
            ? ((target_r[i] - pos_r[i]) > err_lim_r[i])
            : 1'b1) && (target_r[i] != pos_r[i]);
        if (($signed(target_r[i] - pos_r[i]) < 0)
            && (pos_r[i] - target_r[i]) <= err_lim_r[i])
            over_err[i] = 1'b0;
        if (($signed(target_r[i] - pos_r[i]) >= 0)
            && (target_r[i] - pos_r[i]) <= err_lim_r[i])
            over_err[i] = 1'b0;
        err_trip[i] = over_err[i] && (oe_r[i] == OE_MODE_ONE
            || oe_r[i] == OE_MODE_THREE);
        mo_req[i] = wr_axis[i] && reg_idx == A_CTRL
                 && avs_writedata[CTRL_MOTOR_OFF];
        en_req[i] = wr_axis[i] && reg_idx == A_CTRL
                 && avs_writedata[CTRL_ENABLE];
        kill[i] = wdog_trip || mo_req[i] || err_trip[i];
        pos_wr[i] = wr_axis[i] && reg_idx == A_POSITION;
        idx_evt[i] = idx_en_r[i] && enc_idx[i] && !idx_prev_r[i];
        pol_eff[i] = pol_r[POL_PER_AXIS]
            ? pol_r[POL_AXIS_LSB + i]
            : pol_r[POL_GROUP_LSB + i / GROUP_SIZE];
        // a polarity of one means pin high while enabled
        pin_nxt[i] = amp_on[i] ~^ pol_eff[i];
        // command is zeroed while the amplifier is off
        cmd_nxt[i] = 16'h0000;
        if (amp_on[i]) begin
            if ($signed(cmd_r[i]) > $signed({1'b0, tl_r[i]}))
                cmd_nxt[i] = {1'b0, tl_r[i]};
            else if ($signed(cmd_r[i]) < -$signed({1'b0, tl_r[i]}))
                cmd_nxt[i] = 16'(-$signed({1'b0, tl_r[i]}));
            else
                cmd_nxt[i] = cmd_r[i];
        end
    end
end

////////////////////////////////////////////////////////////////////////
// amplifier enable state per axis; a disable wins over an enable
always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        for (int i = 0; i < NUM_AXES; i++) amp_state_r[i] <= AMP_OFF;
        fault_wd_r  <= '0;
        fault_err_r <= '0;
        off_cmd_r   <= '0;
    end else begin
        for (int i = 0; i < NUM_AXES; i++) begin
            case (amp_state_r[i])
                AMP_OFF: begin
                    if (en_req[i] && !kill[i]) begin
                        amp_state_r[i] <= AMP_ON;
                        fault_wd_r[i]  <= 1'b0;
                        fault_err_r[i] <= 1'b0;
                        off_cmd_r[i]   <= 1'b0;
                    end
                end
                AMP_ON: begin
                    if (kill[i]) amp_state_r[i] <= AMP_OFF;
                    if (wdog_trip) fault_wd_r[i] <= 1'b1;
                    if (mo_req[i]) off_cmd_r[i] <= 1'b1;
                    if (err_trip[i]) fault_err_r[i] <= 1'b1;
                end
                default: amp_state_r[i] <= AMP_OFF;
            endcase
        end
    end
end

always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        amp_pin_r <= '0;
        mcmd_r    <= '0;
    end else begin
        amp_pin_r <= pin_nxt;
        for (int i = 0; i < NUM_AXES; i++) mcmd_r[i] <= cmd_nxt[i];
    end
end

////////////////////////////////////////////////////////////////////////
// encoder counting; a host preset of the position wins over a step
always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        for (int i = 0; i < NUM_AXES; i++) begin
            pos_r[i]     <= 32'h0000_0000;
            ab_prev_r[i] <= 2'h0;
        end
        idx_prev_r <= '0;
    end else begin
        for (int i = 0; i < NUM_AXES; i++) begin
            ab_prev_r[i] <= {encoder_input_a[i], encoder_input_b[i]};
            idx_prev_r[i] <= enc_idx[i];
            if (pos_wr[i]) begin
                pos_r[i] <= avs_writedata;
            end else if (pd_r[i]) begin
                if (encoder_input_a[i] && !ab_prev_r[i][1])
                    pos_r[i] <= encoder_input_b[i]
                        ? pos_r[i] + 32'h0000_0001
                        : pos_r[i] - 32'h0000_0001;
            end else begin
                pos_r[i] <= pos_r[i] + 32'(quad_step(
                    {ab_prev_r[i], encoder_input_a[i],
                     encoder_input_b[i]}));
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// per-axis settings written by software
always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        for (int i = 0; i < NUM_AXES; i++) begin
            target_r[i]  <= 32'h0000_0000;
            err_lim_r[i] <= ERR_LIMIT_RST;
            tl_r[i]      <= TORQUE_LIMIT_RST;
            cmd_r[i]     <= 16'h0000;
            base_r[i]    <= HALL_BASE_RST;
            oe_r[i]      <= 2'h0;
        end
        pd_r     <= '0;
        diff_r   <= '0;
        idx_en_r <= '0;
    end else begin
        for (int i = 0; i < NUM_AXES; i++) begin
            if (wr_axis[i]) begin
                case (reg_idx)
                    A_CTRL: begin
                        oe_r[i] <= avs_writedata[CTRL_OE_LSB +: 2];
                        pd_r[i] <= avs_writedata[CTRL_PULSE_DIR];
                        diff_r[i] <= avs_writedata[CTRL_DIFF];
                        idx_en_r[i] <= avs_writedata[CTRL_INDEX_EN];
                    end
                    A_TARGET:    target_r[i]  <= avs_writedata;
                    A_ERR_LIMIT: err_lim_r[i] <= avs_writedata;
                    A_TORQUE:    tl_r[i]      <= avs_writedata[14:0];
                    A_COMMAND:   cmd_r[i]     <= avs_writedata[15:0];
                    A_HALL_BASE: base_r[i]    <= avs_writedata[6:0];
                    default: ;
                endcase
            end
        end
    end
end

// phase estimate is taken one edge after reset release, not under reset
always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        boot_r     <= 1'b1;
        phase_ok_r <= '0;
        for (int i = 0; i < NUM_AXES; i++) phase_r[i] <= 3'h0;
    end else begin
        boot_r <= 1'b0;
        for (int i = 0; i < NUM_AXES; i++) begin
            if (boot_r && hall_ok[i]) begin
                phase_r[i]    <= hall_sector(hall_code[i]);
                phase_ok_r[i] <= 1'b1;
            end else if (wr_axis[i] && reg_idx == A_CTRL
                         && avs_writedata[CTRL_PHASE_SET]) begin
                phase_r[i]    <= avs_writedata[CTRL_PHASE_LSB +: 3];
                phase_ok_r[i] <= 1'b1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// watchdog, shared by all axes; a zero load leaves it idle
assign wdog_reload = wr_acc && glob_hit
    && (reg_idx == G_WDOG_LOAD || reg_idx == G_WDOG_KICK);
assign wdog_trip = wdog_cnt_r == 24'h00_0001 && !wdog_reload;

always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        wdog_load_r <= WDOG_LOAD_RST;
        wdog_cnt_r  <= 24'h00_0000;
    end else begin
        if (wr_acc && glob_hit && reg_idx == G_WDOG_LOAD)
            wdog_load_r <= avs_writedata[23:0];
        if (wdog_reload)
            wdog_cnt_r <= (reg_idx == G_WDOG_LOAD)
                ? avs_writedata[23:0] : wdog_load_r;
        else if (wdog_cnt_r != 24'h00_0000)
            wdog_cnt_r <= wdog_cnt_r - 24'h00_0001;
    end
end

////////////////////////////////////////////////////////////////////////
// interrupts: set beats a write-one-to-clear in the same cycle
assign irq_set = {wdog_trip, idx_evt, amp_on & (err_trip
    | {NUM_AXES{wdog_trip}})};

always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        irq_status_r <= 17'h00000;
        irq_mask_r   <= 17'h00000;
        pol_r        <= POLARITY_RST;
        irq_r        <= 1'b0;
    end else begin
        irq_status_r <= (irq_status_r & ~((wr_acc && glob_hit
            && reg_idx == G_IRQ_STATUS) ? avs_writedata[16:0]
            : 17'h00000)) | irq_set;
        if (wr_acc && glob_hit && reg_idx == G_IRQ_MASK)
            irq_mask_r <= avs_writedata[16:0];
        if (wr_acc && glob_hit && reg_idx == G_POLARITY)
            pol_r <= avs_writedata;
        irq_r <= |(irq_status_r & irq_mask_r);
    end
end

////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge core_clk); endclocking
default disable iff (!rst_n);

wdog_off_a: assert property (wdog_trip |=> amp_on == '0)
    else $error("watchdog trip left an amplifier enabled");
motor_off_a: assert property (mo_req[0] |=> !amp_on[0])
    else $error("motor off did not disable axis 0");
oe_three_a: assert property (
    (oe_r[0] == OE_MODE_THREE && over_err[0]) |=> !amp_on[0])
    else $error("mode three error trip did not disable axis 0");
oe_one_a: assert property (
    (oe_r[0] == OE_MODE_ONE && over_err[0]) |=> ##1 !amp_pin_r[0]
        || !pol_r[POL_GROUP_LSB] || pol_r[POL_PER_AXIS])
    else $error("mode one error trip left axis 0 pin active");
pin_default_a: assert property (
    (pol_r == POLARITY_RST) |=> amp_enable_out == $past(amp_on))
    else $error("default enable pin not active high");
pin_polar_a: assert property (
    (!pol_r[POL_PER_AXIS] && !pol_r[POL_GROUP_LSB + 1])
        |=> amp_enable_out[5] == !$past(amp_on[5]))
    else $error("group polarity not applied to axis 5");
quad_step_a: assert property ((!pos_wr[0] && !pd_r[0])
    |=> (pos_r[0] - $past(pos_r[0])) inside
        {32'h0000_0000, 32'h0000_0001, 32'hFFFF_FFFF})
    else $error("quadrature count moved more than one");
pulse_up_a: assert property ((pd_r[0] && !pos_wr[0]
    && encoder_input_a[0] && !ab_prev_r[0][1] && encoder_input_b[0])
    |=> pos_r[0] == $past(pos_r[0]) + 32'h0000_0001)
    else $error("pulse with direction high did not count up");
tell_pos_a: assert property (
    (avs_read && wait_r && glob_hit == 1'b0
     && avs_address == 9'h104) |=> avs_readdata == $past(pos_r[0])
     && !avs_waitrequest)
    else $error("position read returned wrong value");
clamp_a: assert property (
    $signed(motor_command_out[0]) <= $signed({1'b0, $past(tl_r[0])})
    && $signed(motor_command_out[0])
        >= -$signed({1'b0, $past(tl_r[0])}))
    else $error("motor command exceeded torque limit");
tl_reset_a: assert property (boot_r |->
    tl_r[3] == TORQUE_LIMIT_RST)
    else $error("torque limit not at default after reset");
sticky_off_a: assert property ((!amp_on[0] && !en_req[0])
    |=> !amp_on[0])
    else $error("axis 0 enabled without host request");
hall_est_a: assert property ((boot_r && hall_ok[0])
    |=> phase_ok_r[0] && phase_r[0] == $past(hall_sector(hall_code[0])))
    else $error("hall phase not estimated at reset");
hall_bank_a: assert property (!base_ok(base_r[6])
    |-> !hall_ok[6])
    else $error("hall taken from a non hall bank");

wdog_trip_c: cover property (wdog_trip && amp_on != '0);
err_trip_c:  cover property (amp_on[0] ##1 err_trip[0] ##1 !amp_on[0]);
index_c:     cover property (idx_evt[0] ##2 irq);
read_c:      cover property (avs_read && !avs_waitrequest);

endmodule

// ===== verification/amp_model.sv
`timescale 1ns/1ps
module amp_model
    import axis_amp_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic [NUM_AXES-1:0]        amp_enable_out,
    input  wire logic [NUM_AXES-1:0][15:0]  motor_command_out,
    output logic      [NUM_AXES-1:0]        enc_a,
    output logic      [NUM_AXES-1:0]        enc_b,
    output logic      [96:1]                dig_in
);
    logic        [1:0]  q = 2'h0;
    logic               a0 = 1'b0;
    logic               b0 = 1'b0;
    logic signed [15:0] drive;
    // inhibited amp takes no command; full scale maps to 10 V
    assign drive = amp_enable_out[0]
        ? motor_command_out[0] : 16'sh0000;
    assign enc_a = {7'h00, a0};
    assign enc_b = {7'h00, b0};
    // halls fixed at a valid code on consecutive inputs 1..3
    assign dig_in = {93'h0, 3'h5};
    // gray sequence, one channel moves per step
    task automatic quad(input int d);
        q = q + 2'(d);
        @(posedge core_clk);
        a0 <= q[1];
        b0 <= q[1] ^ q[0];
        repeat (3) @(posedge core_clk);
    endtask
    task automatic pulse(input logic dir);
        @(posedge core_clk);
        b0 <= dir;
        @(posedge core_clk);
        a0 <= 1'b1;
        repeat (3) @(posedge core_clk);
        a0 <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
endmodule

// ===== verification/test_axis_amp_enable_safety.sv
`timescale 1ns/1ps
module test_axis_amp_enable_safety
    import axis_amp_pkg::*;
;
    logic             core_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0;
    logic             avs_write = 1'b0, avs_waitrequest, irq;
    logic [8:0]       avs_address = 9'h000;
    logic [31:0]      avs_writedata = 32'h0, avs_readdata, rd_v;
    logic [7:0]       enc_a, enc_b, amp_enable_out;
    logic [7:0]       enc_i = 8'h00, enc_in = 8'hFF;
    logic [7:0][15:0] motor_command_out;
    logic [96:1]      dig_in;
    int               n_errors = 0, compares = 0;
    axis_amp_enable_safety axis_amp_enable_safety_i (.core_clk(core_clk),
        .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(4'hF),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .encoder_chan_a_pos(enc_a),
        .encoder_chan_a_neg(~enc_a), .encoder_chan_b_pos(enc_b),
        .encoder_chan_b_neg(~enc_b), .encoder_index_pos(enc_i),
        .encoder_index_neg(enc_in), .dig_in(dig_in),
        .amp_enable_out(amp_enable_out),
        .motor_command_out(motor_command_out), .irq(irq));
    amp_model amp_model_i (.core_clk(core_clk), .amp_enable_out(amp_enable_out),
        .motor_command_out(motor_command_out), .enc_a(enc_a), .enc_b(enc_b),
        .dig_in(dig_in));
    ////////////////////////////////////////////////////////////////////////
    initial forever #50 core_clk = ~core_clk;
    function automatic logic [8:0] ax(input logic [2:0] w);
        return {4'h8, w, 2'h0};
    endfunction
    function automatic logic [8:0] g(input logic [2:0] w);
        return {4'h0, w, 2'h0};
    endfunction
    // request held until the edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [8:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        if (wr) avs_write <= 1'b1; else avs_read <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd_v = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [8:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic settle();
        repeat (4) @(posedge core_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // whole run is a few hundred cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(g(G_POLARITY)); chk(rd_v, POLARITY_RST);
        rd(ax(A_ERR_LIMIT)); chk(rd_v, 32'h0000_07D0);
        rd(ax(A_TORQUE)); chk(rd_v, 32'h0000_7FDE);
        rd(g(3'h5)); chk(rd_v, 32'h0);
        rd(ax(A_STATUS)); chk({31'h0, rd_v[4]}, 32'h1);
        repeat (4) amp_model_i.quad(1);
        rd(ax(A_POSITION)); chk(rd_v, 32'h4);
        for (int i = 0; i < 4; i++) begin
            amp_model_i.quad(i[0] ? -1 : 1);
            rd(ax(A_POSITION)); chk(rd_v, i[0] ? 32'h4 : 32'h5);
        end
        wr(ax(A_CTRL), 32'h100);
        repeat (3) amp_model_i.pulse(1'b1);
        amp_model_i.pulse(1'b0);
        rd(ax(A_POSITION)); chk(rd_v, 32'h6);
        wr(ax(A_CTRL), 32'h1); wr(ax(A_TORQUE), 32'h100);
        wr(ax(A_COMMAND), 32'h7000); settle();
        chk({31'h0, amp_enable_out[0]}, 32'h1);
        chk({16'h0, motor_command_out[0]}, 32'h0100);
        wr(ax(A_COMMAND), 32'h9000); settle();
        chk({16'h0, motor_command_out[0]}, 32'hFF00);
        chk({16'h0, amp_model_i.drive}, 32'hFF00);
        wr(ax(A_CTRL), 32'h2); settle();
        chk({31'h0, amp_enable_out[0]}, 32'h0);
        wr(ax(A_POSITION), 0); wr(ax(A_TARGET), 0);
        wr(ax(A_ERR_LIMIT), 2); wr(g(G_IRQ_MASK), 1);
        for (int m = 1; m < 4; m += 2) begin
            wr(ax(A_CTRL), 32'h1 | (32'(m) << 4));
            wr(ax(A_POSITION), 2); settle();
            chk({31'h0, amp_enable_out[0]}, 32'h1);
            wr(ax(A_POSITION), 3); settle();
            chk({31'h0, amp_enable_out[0]}, 32'h0);
            chk({31'h0, irq}, 32'h1);
            wr(ax(A_POSITION), 0); settle();
            chk({31'h0, amp_enable_out[0]}, 32'h0);
            wr(g(G_IRQ_STATUS), 1); settle(); chk({31'h0, irq}, 32'h0);
        end
        wr(ax(A_CTRL), 32'h1); wr(g(G_WDOG_LOAD), 5);
        repeat (8) @(posedge core_clk);
        chk({31'h0, amp_enable_out[0]}, 32'h0);
        rd(g(G_IRQ_STATUS)); chk({31'h0, rd_v[16]}, 32'h1);
        wr(g(G_WDOG_LOAD), 0);
        wr(g(G_POLARITY), 0); settle();
        chk({24'h0, amp_enable_out}, 32'hFF);
        wr(g(G_POLARITY), 32'h000F_0100); settle();
        chk({24'h0, amp_enable_out}, 32'hF0);
        // differential index edge raises its sticky bit and the irq
        wr(ax(A_CTRL), 32'h600); wr(g(G_IRQ_MASK), 32'h100);
        wr(g(G_IRQ_STATUS), 32'h0001_FFFF);
        enc_i <= 8'h01; enc_in <= 8'hFE; settle();
        chk({31'h0, irq}, 32'h1);
        rd(g(G_IRQ_STATUS)); chk({31'h0, rd_v[8]}, 32'h1);
        report_and_stop();
    end
endmodule
